// >>> core/dtm_torque_removal_monitor.sv
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`include "dtm_cfg.svh"
module dtm_torque_removal_monitor #(
   parameter int SHORT_CYCLES = `DTM_SHORT_MS * `DTM_CLK_KHZ,
   parameter int LONG_CYCLES = `DTM_LONG_MS * `DTM_CLK_KHZ
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // safety enable inputs, high = energised
   input wire logic enableA,
   input wire logic enableB,
   // power stage and status
   output logic gateEn,
   output logic stopRequestFlag,
   output logic torqueRemovalInhibitState,
   output logic channelMismatchFault,
   output logic irq,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`DTM_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr
);
   localparam logic [`DTM_TMR_W-1:0] SHORT_CYC = `DTM_TMR_W'(SHORT_CYCLES);
   localparam logic [`DTM_TMR_W-1:0] LONG_CYC = `DTM_TMR_W'(LONG_CYCLES);

   dtm_pkg::dtm_regs_type r;
   dtm_pkg::dtm_regs_type next_r;
   logic [1:0] chOn;
   logic bothOn;
   logic bothOff;
   logic setupPhase;
   logic accessPhase;

   // ----------------------------------------
   // input synchroniser
   // ----------------------------------------
   dtm_sync u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({enableB, enableA}),
      .q(chOn)
   );

   assign bothOn = chOn[0] & chOn[1];
   assign bothOff = ~(chOn[0] | chOn[1]);
   assign setupPhase = psel & ~penable;
   assign accessPhase = psel & penable & r.pready;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [`DTM_EV_W-1:0] ev;
      logic [`DTM_EV_W-1:0] clr;
      logic firstBackOn;
      ev = '0;
      clr = '0;
      firstBackOn = r.firstOffA ? chOn[0] : chOn[1];
      next_r = r;
      next_r.motionFaultResetCommand = 1'b0;

      // window timer saturates at the long window
      if (r.timer < LONG_CYC) begin
         next_r.timer = r.timer + 1'b1;
      end

      // both-off qualification for fault reset
      if (!bothOff) begin
         next_r.offCnt = '0;
      end else if (r.offCnt <= LONG_CYC) begin
         next_r.offCnt = r.offCnt + 1'b1;
      end

      // mismatch is judged only while a demand sequence runs
      unique case (r.state)
         dtm_pkg::S_RUN, dtm_pkg::S_HOLD: begin
            if (!bothOn) begin
               next_r.timer = '0;
               next_r.firstOffA = ~chOn[0];
               next_r.state = bothOff ? dtm_pkg::S_BOTH_OFF : dtm_pkg::S_ONE_OFF;
            end else if (r.state == dtm_pkg::S_HOLD && r.timer >= LONG_CYC) begin
               next_r.state = dtm_pkg::S_RUN;
            end
         end
         dtm_pkg::S_ONE_OFF: begin
            if (bothOff) begin
               next_r.state = dtm_pkg::S_BOTH_OFF;
            end else if (firstBackOn) begin
               next_r.state = dtm_pkg::S_FAULT;
            end else if (r.timer >= LONG_CYC) begin
               next_r.state = dtm_pkg::S_FAULT;
            end
         end
         dtm_pkg::S_BOTH_OFF: begin
            if (!bothOff) begin
               next_r.timer = '0;
               next_r.state = bothOn ? dtm_pkg::S_RUN : dtm_pkg::S_ONE_ON;
            end
         end
         dtm_pkg::S_ONE_ON: begin
            if (bothOn) begin
               if (r.timer < SHORT_CYC) begin
                  next_r.state = dtm_pkg::S_RUN;
               end else begin
                  next_r.state = dtm_pkg::S_HOLD;
               end
            end else if (bothOff) begin
               next_r.state = dtm_pkg::S_BOTH_OFF;
            end else if (r.timer >= LONG_CYC) begin
               next_r.state = dtm_pkg::S_FAULT;
            end
         end
         dtm_pkg::S_FAULT: begin
            // a reset that comes too early is dropped, not queued
            if (r.motionFaultResetCommand) begin
               if (bothOff && r.offCnt > LONG_CYC) begin
                  next_r.state = dtm_pkg::S_BOTH_OFF;
                  ev[`DTM_EV_CLEARED] = 1'b1;
               end else begin
                  ev[`DTM_EV_REFUSED] = 1'b1;
               end
            end
         end
         default: begin
            next_r.state = dtm_pkg::S_FAULT;
         end
      endcase

      if (r.state == dtm_pkg::S_RUN && next_r.state != dtm_pkg::S_RUN) begin
         ev[`DTM_EV_STOP] = 1'b1;
      end
      if (r.state != dtm_pkg::S_FAULT && next_r.state == dtm_pkg::S_FAULT) begin
         ev[`DTM_EV_FAULT] = 1'b1;
      end

      // coast stop: gates drop with no ramp
      next_r.gateEn = (next_r.state == dtm_pkg::S_RUN) & bothOn;
      next_r.stopRequestFlag = next_r.state != dtm_pkg::S_RUN;
      next_r.torqueRemovalInhibitState = ~bothOn;
      next_r.channelMismatchFault = next_r.state == dtm_pkg::S_FAULT;

      // ----------------------------------------
      // apb
      // ----------------------------------------
      next_r.pready = setupPhase;
      next_r.pslverr = 1'b0;
      next_r.prdata = '0;
      if (setupPhase) begin
         unique case (paddr)
            `DTM_OFS_STATUS_WORD: begin
               next_r.prdata[`DTM_SW_STOP] = r.stopRequestFlag;
               next_r.prdata[`DTM_SW_INHIBIT] = r.torqueRemovalInhibitState;
               next_r.prdata[`DTM_SW_FAULT] = r.channelMismatchFault;
               next_r.prdata[`DTM_SW_GATE] = r.gateEn;
               next_r.prdata[`DTM_SW_CHA] = chOn[0];
               next_r.prdata[`DTM_SW_CHB] = chOn[1];
               next_r.prdata[`DTM_SW_STATE +: 3] = r.state;
            end
            `DTM_OFS_EVENTS: begin
               next_r.prdata[`DTM_EV_W-1:0] = r.events;
            end
            `DTM_OFS_MASK: begin
               next_r.prdata[`DTM_EV_W-1:0] = r.mask;
            end
            `DTM_OFS_COMMAND: begin
               next_r.prdata = '0;
            end
            default: begin
               next_r.pslverr = 1'b1;
            end
         endcase
      end
      if (accessPhase) begin
         if (pwrite && paddr == `DTM_OFS_MASK) begin
            next_r.mask = pwdata[`DTM_EV_W-1:0];
         end
         if (pwrite && paddr == `DTM_OFS_COMMAND) begin
            next_r.motionFaultResetCommand = pwdata[`DTM_CMD_RESET];
         end
         if (!pwrite && paddr == `DTM_OFS_EVENTS) begin
            clr = r.events;
         end
      end
      // an event in the clearing cycle survives
      next_r.events = (r.events & ~clr) | ev;
      next_r.irq = |(next_r.events & next_r.mask);
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{
            state: dtm_pkg::S_BOTH_OFF,
            stopRequestFlag: 1'b1,
            torqueRemovalInhibitState: 1'b1,
            mask: `DTM_MASK_RST,
            default: '0
         };
      end else begin
         r <= next_r;
      end
   end

   assign gateEn = r.gateEn;
   assign stopRequestFlag = r.stopRequestFlag;
   assign torqueRemovalInhibitState = r.torqueRemovalInhibitState;
   assign channelMismatchFault = r.channelMismatchFault;
   assign irq = r.irq;
   assign pready = r.pready;
   assign prdata = r.prdata;
   assign pslverr = r.pslverr;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   gate_pin_off_a: assert property (
      !(enableA && enableB) |-> ##[1:3] !gateEn)
      else $error("gate still on after an enable input dropped");
   gate_off_a: assert property (!bothOn |=> !gateEn)
      else $error("gate on while an input is off");
   stop_set_a: assert property ($fell(bothOn) |=> stopRequestFlag)
      else $error("stop request not raised");
   inhibit_a: assert property (!bothOn |=> torqueRemovalInhibitState)
      else $error("inhibit state not reported");
   late_second_a: assert property (
      r.state == dtm_pkg::S_ONE_OFF && r.timer >= LONG_CYC && !bothOff
      && !(r.firstOffA ? chOn[0] : chOn[1]) |=> ##1 channelMismatchFault)
      else $error("late second drop not faulted");
   early_reon_a: assert property (
      r.state == dtm_pkg::S_ONE_OFF && bothOn |=> ##1 channelMismatchFault)
      else $error("early return not faulted");
   late_reon_a: assert property (
      r.state == dtm_pkg::S_ONE_ON && !bothOn && !bothOff && r.timer >= LONG_CYC
      |=> ##1 channelMismatchFault)
      else $error("late second return not faulted");
   quick_clear_a: assert property (
      r.state == dtm_pkg::S_ONE_ON && bothOn && r.timer < SHORT_CYC
      |=> !stopRequestFlag ##1 gateEn)
      else $error("stop request not cleared at once");
   hold_stop_a: assert property (
      r.state == dtm_pkg::S_HOLD && r.timer < LONG_CYC && bothOn |=> stopRequestFlag)
      else $error("stop request cleared before the long window");
   reset_gate_a: assert property (
      channelMismatchFault && r.motionFaultResetCommand && r.offCnt <= LONG_CYC
      |=> ##1 channelMismatchFault)
      else $error("fault cleared before qualification");
   fault_latch_a: assert property (
      channelMismatchFault && !$past(r.motionFaultResetCommand) |-> !gateEn
      ##1 channelMismatchFault || $past(r.motionFaultResetCommand))
      else $error("fault released without a reset");
   demand_only_a: assert property (
      $rose(r.state == dtm_pkg::S_FAULT) |-> $past(r.state) != dtm_pkg::S_RUN)
      else $error("fault raised with no demand");
   irq_a: assert property (##1 irq == |($past(next_r.events) & $past(next_r.mask)))
      else $error("interrupt does not follow events and mask");

   quick_cov_c: cover property (r.state == dtm_pkg::S_ONE_ON ##1 r.state == dtm_pkg::S_RUN);
   hold_cov_c: cover property (r.state == dtm_pkg::S_HOLD ##1 r.state == dtm_pkg::S_RUN);
   fault_cov_c: cover property ($rose(channelMismatchFault));
   cleared_cov_c: cover property ($fell(channelMismatchFault));
endmodule : dtm_torque_removal_monitor

// >>> core/dtm_cfg.svh
// Notes on behaviour
// - either enable input off forces every power transistor gate off.
// - gate shutdown completes well under 12 ms after an input drops.
// - power is removed at once, no deceleration: uncontrolled coast stop.
// - stop request flag goes to 1 when any enable input switches off.
// - inhibit state is reported while any enable input is off.
// - second input must drop within 1 s of the first, else mismatch fault.
// - first input returning on before the second dropped posts mismatch fault.
// - second input must return within 1 s of the first, else mismatch fault.
// - second input on within 100 ms clears stop request at once.
// - second input on after 100 ms clears stop request only at 1 s.
// - fault reset accepted only after both inputs off for over 1 s.
// - mismatch is judged only on input transitions, no background test.
`ifndef DTM_CFG_SVH
`define DTM_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define DTM_CLK_KHZ 25000
`define DTM_SHORT_MS 100
`define DTM_LONG_MS 1000
`define DTM_RESP_MS 12
`define DTM_GATE_LAT 3
`define DTM_TMR_W 26

// ----------------------------------------
// register map
// ----------------------------------------
`define DTM_ADDR_W 12
`define DTM_OFS_STATUS_WORD 12'h000
`define DTM_OFS_EVENTS 12'h004
`define DTM_OFS_MASK 12'h008
`define DTM_OFS_COMMAND 12'h00c

// ----------------------------------------
// fields
// ----------------------------------------
`define DTM_SW_STOP 0
`define DTM_SW_INHIBIT 1
`define DTM_SW_FAULT 2
`define DTM_SW_GATE 3
`define DTM_SW_CHA 4
`define DTM_SW_CHB 5
`define DTM_SW_STATE 6
`define DTM_EV_W 4
`define DTM_EV_STOP 0
`define DTM_EV_FAULT 1
`define DTM_EV_CLEARED 2
`define DTM_EV_REFUSED 3
`define DTM_CMD_RESET 0
`define DTM_MASK_RST 4'h0

`endif

// >>> core/dtm_pkg.sv
`include "dtm_cfg.svh"
package dtm_pkg;
   typedef enum logic [2:0] {
      S_RUN = 3'b000,
      S_ONE_OFF = 3'b001,
      S_BOTH_OFF = 3'b011,
      S_ONE_ON = 3'b010,
      S_HOLD = 3'b110,
      S_FAULT = 3'b111
   } dtm_state_type;

   typedef struct packed {
      dtm_state_type state;
      logic [`DTM_TMR_W-1:0] timer;
      logic [`DTM_TMR_W-1:0] offCnt;
      logic firstOffA;
      logic gateEn;
      logic stopRequestFlag;
      logic torqueRemovalInhibitState;
      logic channelMismatchFault;
      logic irq;
      logic motionFaultResetCommand;
      logic [`DTM_EV_W-1:0] events;
      logic [`DTM_EV_W-1:0] mask;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } dtm_regs_type;

   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] q;
   } dtm_sync_type;
endpackage : dtm_pkg

// >>> core/dtm_sync.sv
`timescale 1ns/1ps
module dtm_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // raw and synchronised levels
   input wire logic [1:0] d,
   output logic [1:0] q
);
   dtm_pkg::dtm_sync_type r;
   dtm_pkg::dtm_sync_type next_r;

   // meta is read only by the second stage
   always_comb begin
      next_r = r;
      next_r.meta = d;
      next_r.q = r.meta;
   end

   // reset to "off": a dead input must look de-energised
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.q;
endmodule : dtm_sync

// >>> tb/dtm_safety_dev.sv
`timescale 1ns/1ps
module dtm_safety_dev (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // demanded level and channel lag in cycles
   input wire logic wantOn,
   input wire logic [15:0] lag,
   // safety enable pins
   output logic enableA,
   output logic enableB
);
   logic [15:0] cnt;

   // ----------------------------------------
   // channels
   // ----------------------------------------
   // b trails a by lag+1 cycles; a lag beyond the window is a deliberate mismatch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enableA <= 1'b0;
         enableB <= 1'b0;
         cnt <= 16'h0000;
      end else begin
         enableA <= wantOn;
         if (enableB == enableA) begin
            cnt <= lag;
         end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
         end else begin
            enableB <= enableA;
         end
      end
   end
endmodule : dtm_safety_dev

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "dtm_cfg.svh"
module testbench;
   localparam int SHORT = 20;
   localparam int LONG = 100;
   typedef struct {
      int offLag;
      int onLag;
      logic fault;
      logic late;
   } dtm_row_type;
   dtm_row_type rows [4];
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wantOn = 1'b0;
   logic [15:0] lag = 16'h0000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [`DTM_ADDR_W-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic enableA, enableB, gateEn, stopRequestFlag, torqueRemovalInhibitState;
   logic channelMismatchFault, irq, pready, pslverr, er;
   logic [31:0] prdata, rd;
   int nErrors = 0;
   int checksDone = 0;

   always #20 clk = ~clk;

   dtm_safety_dev partner_u (.clk(clk), .rst_n(rst_n), .wantOn(wantOn), .lag(lag),
      .enableA(enableA), .enableB(enableB));
   dtm_torque_removal_monitor #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) dut_u (
      .clk(clk), .rst_n(rst_n), .enableA(enableA), .enableB(enableB), .gateEn(gateEn),
      .stopRequestFlag(stopRequestFlag), .torqueRemovalInhibitState(torqueRemovalInhibitState),
      .channelMismatchFault(channelMismatchFault), .irq(irq), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task printVerdict;
      $display("errors %0d checks %0d", nErrors, checksDone);
      if (nErrors == 0 && checksDone > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : printVerdict

   task check(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         nErrors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // checks land on the falling edge, away from the updates
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   // request held until the rising edge that sees pready high; data taken there
   task apb(input logic wr, input logic [`DTM_ADDR_W-1:0] a, input logic [31:0] wd);
      int i;
      i = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         i++;
         if (i > 20) begin
            nErrors++;
            printVerdict();
         end
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // early reset must be refused and flagged, the late one accepted
   task recover;
      @(posedge clk);
      wantOn <= 1'b0;
      lag <= 16'h0000;
      cyc(10);
      apb(1'b1, `DTM_OFS_COMMAND, 32'h00000001);
      cyc(4);
      check(32'(channelMismatchFault), 32'h00000001);
      check(32'(irq), 32'h00000001);
      apb(1'b0, `DTM_OFS_EVENTS, 32'h00000000);
      check(rd & 32'h00000008, 32'h00000008);
      cyc(3);
      check(32'(irq), 32'h00000000);
      cyc(LONG + 10);
      apb(1'b1, `DTM_OFS_COMMAND, 32'h00000001);
      cyc(4);
      check(32'(channelMismatchFault), 32'h00000000);
      @(posedge clk);
      wantOn <= 1'b1;
      cyc(10);
      check(32'(gateEn), 32'h00000001);
   endtask : recover

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      rows[0] = '{5, 5, 1'b0, 1'b0};
      rows[1] = '{5, 50, 1'b0, 1'b1};
      rows[2] = '{150, 5, 1'b1, 1'b0};
      rows[3] = '{5, 150, 1'b1, 1'b0};
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(32'({gateEn, stopRequestFlag, torqueRemovalInhibitState, channelMismatchFault, irq}),
         32'h0000000c);
      @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, `DTM_OFS_MASK, 32'h00000000);
      check(rd, 32'h00000000);
      apb(1'b0, 12'h010, 32'h00000000);
      check(32'(er), 32'h00000001);
      check(rd, 32'h00000000);
      apb(1'b1, `DTM_OFS_MASK, 32'h00000008);
      apb(1'b0, `DTM_OFS_MASK, 32'h00000000);
      check(rd, 32'h00000008);
      apb(1'b0, `DTM_OFS_EVENTS, 32'h00000000);
      @(posedge clk);
      wantOn <= 1'b1;
      cyc(10);
      apb(1'b0, `DTM_OFS_STATUS_WORD, 32'h00000000);
      check(rd, 32'h00000038);
      for (int r = 0; r < 4; r++) begin
         @(posedge clk);
         lag <= 16'(rows[r].offLag);
         wantOn <= 1'b0;
         cyc(5);
         check(32'(gateEn), 32'h00000000);
         check(32'(stopRequestFlag), 32'h00000001);
         check(32'(torqueRemovalInhibitState), 32'h00000001);
         cyc(rows[r].offLag + 10);
         @(posedge clk);
         lag <= 16'(rows[r].onLag);
         wantOn <= 1'b1;
         cyc(rows[r].onLag + 8);
         check(32'(stopRequestFlag), 32'(rows[r].late | rows[r].fault));
         cyc(LONG + 10);
         check(32'(stopRequestFlag), 32'(rows[r].fault));
         check(32'(channelMismatchFault), 32'(rows[r].fault));
         check(32'(gateEn), 32'(!rows[r].fault));
         if (rows[r].fault) begin
            recover();
         end
      end
      @(posedge clk);
      lag <= 16'h01f4;
      wantOn <= 1'b0;
      cyc(20);
      @(posedge clk);
      wantOn <= 1'b1;
      cyc(10);
      check(32'(channelMismatchFault), 32'h00000001);
      recover();
      printVerdict();
   end
endmodule : testbench
